// >>> hdl/prs_pkg.sv
// Shared constants, states and carrier types of the pixel readout sequencer
package prs_pkg;
    // Geometry
    localparam int unsigned ROWS_N      = 128;   // Rows per subframe
    localparam int unsigned COLS_N      = 64;    // Active columns per row
    localparam int unsigned DUMMIES_N   = 2;     // Dummy pixels leading each row
    localparam int unsigned POS_N       = COLS_N + DUMMIES_N; // Column slots per row
    localparam int unsigned SLOTS_N     = 10;    // Serial slots per pixel index
    localparam int unsigned LATENCY_N   = 4;     // Readout ticks before first sample
    localparam int unsigned SAMPLE_W    = 8;     // Width of one sample word
    localparam int unsigned ROW_W       = 7;     // Row counter width
    localparam int unsigned POS_W       = 7;     // Column slot counter width
    localparam int unsigned SLOT_W      = 4;     // Serial slot counter width

    // Counter limits at their widths
    localparam logic [ROW_W-1:0]  ROW_TOP      = 7'h7f;  // First row read
    localparam logic [ROW_W-1:0]  ROW_BOTTOM   = 7'h00;  // Last row read
    localparam logic [POS_W-1:0]  POS_DUMMY1   = 7'h00;  // Slot of dummy pixel one
    localparam logic [POS_W-1:0]  POS_DUMMY0   = 7'h01;  // Slot of dummy pixel zero
    localparam logic [POS_W-1:0]  POS_LAST     = 7'h41;  // Slot of column 0
    localparam logic [SLOT_W-1:0] SLOT_LAST    = 4'h9;   // Last serial slot
    localparam logic [SLOT_W-1:0] SLOT_HALF    = 4'h5;   // Clock-out high below this
    localparam logic [SLOT_W-1:0] SLOT_LEFT    = 4'h0;   // Left subframe slot
    localparam logic [SLOT_W-1:0] SLOT_RIGHT   = 4'h1;   // Right subframe slot
    localparam logic [2:0]        LAT_LAST     = 3'h3;   // Last latency tick

    // APB register byte offsets
    localparam logic [7:0] REG_MODE   = 8'h00;  // Readout mode configuration
    localparam logic [7:0] REG_LEVELS = 8'h04;  // Test levels, high and low
    localparam logic [7:0] REG_STATUS = 8'h08;  // Row, column slot, state
    localparam logic [7:0] REG_FRAMES = 8'h0c;  // Completed frame count

    // Mode register fields
    localparam int unsigned MODE_SERIAL = 0;    // 1: interleaved serial output
    localparam int unsigned MODE_TEST   = 1;    // 1: test levels replace pixels
    localparam int unsigned MODE_TOGGLE = 4;    // 1: first marker toggles per pixel
    localparam logic [4:0]  MODE_RESET  = 5'h14;
    localparam logic [15:0] LEVELS_RESET = 16'h0000;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_RUN   = 4'b1000
    } prs_state_type;

    // One buffered output word
    typedef struct packed {
        logic [SAMPLE_W-1:0] left;      // Left subframe or serial sample
        logic [SAMPLE_W-1:0] right;     // Right subframe sample
        logic                first;     // Sampling helper marker
        logic                row_end;   // Last column of row
        logic                frame_end; // Last row of frame
    } prs_word_type;
endpackage : prs_pkg

// >>> hdl/prs_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module prs_fifo #(
    parameter int unsigned WIDTH = 19,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_in,     // System clock
    input  wire logic             rst_n_in,   // Synchronised reset
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic [WIDTH-1:0]      rd_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);

    // Power of two depth keeps pointer wrap free
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("prs_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
    logic [AW:0]      wr_q;           // Write pointer with wrap bit
    logic [AW:0]      rd_q;           // Read pointer with wrap bit
    logic             push;
    logic             pop;

    // Honest flags from pointer difference
    assign wr_ready_out = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign rd_valid_out = wr_q != rd_q;
    assign push         = wr_valid_in && wr_ready_out;
    assign pop          = rd_valid_out && rd_ready_in;
    assign rd_data_out  = mem_q[rd_q[AW-1:0]];

    // Storage write, no reset needed
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= wr_data_in;
        end
    end

    // Pointers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : prs_fifo

// >>> hdl/prs_sequencer.sv
// Pixel readout sequencer: frame ordering, test pattern, markers, APB registers
`timescale 1ns/1ps
module prs_sequencer import prs_pkg::*; #(
    parameter int unsigned FIFO_DEPTH = 8
) (
    input  wire logic                clk_in,          // 50 MHz system clock
    input  wire logic                rstn_in,         // Asynchronous reset, low active
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Readout control and matrix side
    input  wire logic                sync_token_in,       // Start token, high arms
    input  wire logic [SAMPLE_W-1:0] left_pixel_in,       // Left subframe pixel value
    input  wire logic [SAMPLE_W-1:0] right_pixel_in,      // Right subframe pixel value
    input  wire logic [SAMPLE_W-1:0] dummy_level_input_in, // Level for serial dummy slots
    output logic [ROW_W-1:0]         row_addr_out,        // Selected matrix row
    output logic [5:0]               col_addr_out,        // Selected matrix column
    output logic                     matrix_select_out,   // Matrix drives the mux
    output logic                     readout_clock_out,   // Divided readout clock
    output logic                     start_marker_out,    // Pulse: readout begins
    output logic                     reset_marker_out,    // Level: readout logic held
    // Buffered sample stream
    output logic                     out_valid_out,
    input  wire logic                out_ready_in,
    output logic [SAMPLE_W-1:0]      left_sample_out,     // Left or serial sample
    output logic [SAMPLE_W-1:0]      right_sample_out,    // Right subframe sample
    output logic                     sample_first_out,    // Sampling helper marker
    output logic                     row_end_out,         // Row end marker
    output logic                     frame_end_out        // Frame end marker
);
    if (FIFO_DEPTH < 2) begin : g_depth_check
        $error("prs_sequencer needs a FIFO of at least two words");
    end

    // Reset release through two flops
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // Test pattern level for a column slot: period four, left HLLH
    function automatic logic [SAMPLE_W-1:0] test_level(
        input logic [POS_W-1:0]    pos,
        input logic                left,
        input logic [SAMPLE_W-1:0] hi,
        input logic [SAMPLE_W-1:0] lo
    );
        logic h;
        h = (pos[1] == pos[0]) ? left : !left;
        return h ? hi : lo;
    endfunction : test_level

    // Registers and state
    logic [4:0]          mode_q;        // Software mode word
    logic [4:0]          run_mode_q;    // Mode latched at readout start
    logic [15:0]         levels_q;      // Test high [7:0], low [15:8]
    prs_state_type       state_q;
    logic [SLOT_W-1:0]   slot_q;        // Serial slot and clock divider
    logic [2:0]          lat_q;         // Start latency count
    logic [ROW_W-1:0]    row_q;         // Current row
    logic [POS_W-1:0]    pos_q;         // Current column slot
    logic [15:0]         frames_q;      // Completed frames
    logic                first_pend_q;  // First pixel of first frame not yet sent
    logic                first_tgl_q;   // Toggling helper marker
    logic                clk_out_q;
    logic                start_q;
    prs_word_type        word;
    prs_word_type        rd_word;
    logic                push_need;
    logic                fifo_ready;
    logic                adv;           // Whole sequencer may step
    logic                tick;          // Readout clock edge enable
    logic                serial;
    logic                test;
    logic [SAMPLE_W-1:0] lvl_hi;
    logic [SAMPLE_W-1:0] lvl_lo;
    logic [SAMPLE_W-1:0] left_val;
    logic [SAMPLE_W-1:0] right_val;
    logic                apb_wr;
    logic                apb_hit;

    assign serial = run_mode_q[MODE_SERIAL];
    assign test   = run_mode_q[MODE_TEST];
    assign lvl_hi = levels_q[7:0];
    assign lvl_lo = levels_q[15:8];

    // A stalled FIFO freezes the divider, so no sample is ever dropped
    assign adv  = !(push_need && !fifo_ready);
    assign tick = adv && (slot_q == SLOT_LAST);

    // Divider by ten doubles as the serial slot count
    // divide by ten
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            slot_q    <= '0;
            clk_out_q <= 1'b0;
        end else if (adv) begin
            slot_q    <= (slot_q == SLOT_LAST) ? '0 : slot_q + 1'b1;
            clk_out_q <= (slot_q == SLOT_LAST) || (slot_q < SLOT_HALF - 1'b1);
        end
    end
    assign readout_clock_out = clk_out_q;

    // Readout state: token high arms, low sampled starts the latency
    // latency then run
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            lat_q   <= '0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (tick) begin
                if (sync_token_in) begin
                    state_q <= ST_ARMED;
                    lat_q   <= '0;
                end else begin
                    case (state_q)
                        ST_IDLE:  state_q <= ST_IDLE;   // Wait for a token
                        ST_ARMED: state_q <= ST_WAIT;   // Token low seen
                        ST_WAIT: begin
                            lat_q <= lat_q + 1'b1;
                            if (lat_q == LAT_LAST) begin
                                state_q <= ST_RUN;
                                start_q <= 1'b1;
                            end
                        end
                        ST_RUN:   state_q <= ST_RUN;    // Frames repeat
                        default:  state_q <= ST_IDLE;   // Illegal code recovers
                    endcase
                end
            end
        end
    end
    assign start_marker_out = start_q;
    assign reset_marker_out = (state_q == ST_IDLE) || (state_q == ST_ARMED);

    // Mode latched while not running so a write cannot tear a frame
    // latch mode
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            run_mode_q <= MODE_RESET;
        end else if (state_q != ST_RUN) begin
            run_mode_q <= mode_q;
        end
    end

    // Row and column slot counters; a token restarts them at once
    // counters
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            row_q    <= ROW_TOP;
            pos_q    <= POS_DUMMY1;
            frames_q <= '0;
        end else if (tick) begin
            if (state_q != ST_RUN || sync_token_in) begin
                row_q <= ROW_TOP;
                pos_q <= POS_DUMMY1;
            end else if (pos_q == POS_LAST) begin
                pos_q <= POS_DUMMY1;
                row_q <= row_q - 1'b1;
                if (row_q == ROW_BOTTOM) begin
                    frames_q <= frames_q + 1'b1;
                end
            end else begin
                pos_q <= pos_q + 1'b1;
            end
        end
    end

    // Matrix addressing: slot 2 is column 63, slot 65 is column 0
    // matrix cut in test
    assign row_addr_out      = row_q;
    assign col_addr_out      = 6'(POS_LAST - pos_q);
    assign matrix_select_out = (state_q == ST_RUN) && !test && (pos_q > POS_DUMMY0);

    // Sample values for the current column slot
    // alternating test levels
    always_comb begin
        if (test) begin
            left_val  = test_level(pos_q, 1'b1, lvl_hi, lvl_lo);
            right_val = test_level(pos_q, 1'b0, lvl_hi, lvl_lo);
        end else if (pos_q == POS_DUMMY1) begin
            left_val  = lvl_hi;
            right_val = lvl_hi;
        end else if (pos_q == POS_DUMMY0) begin
            left_val  = lvl_lo;
            right_val = lvl_lo;
        end else begin
            left_val  = left_pixel_in;
            right_val = right_pixel_in;
        end
    end

    // Helper marker sources
    // first-only or toggle
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            first_pend_q <= 1'b1;
            first_tgl_q  <= 1'b0;
        end else begin
            if (push_need && fifo_ready && slot_q == SLOT_LEFT) begin
                first_pend_q <= 1'b0;
            end
            if (tick && state_q == ST_RUN) begin
                first_tgl_q <= !first_tgl_q;
            end
        end
    end

    // Word for the buffer; serial mode pushes every slot, parallel one per index
    // interleave subframe groups
    always_comb begin
        push_need = (state_q == ST_RUN) && (serial || slot_q == SLOT_LEFT);
        word      = '0;
        if (!serial) begin
            word.left  = left_val;
            word.right = right_val;
        end else if (slot_q == SLOT_LEFT) begin
            word.left = left_val;
        end else if (slot_q == SLOT_RIGHT) begin
            word.left = right_val;
        end else begin
            word.left = dummy_level_input_in;
        end
        word.first     = run_mode_q[MODE_TOGGLE] ? first_tgl_q
                                                 : (first_pend_q && slot_q == SLOT_LEFT);
        word.row_end   = (pos_q == POS_LAST);
        word.frame_end = (row_q == ROW_BOTTOM);
    end

    // Output buffer; its ready stalls the sequencer
    prs_fifo #(
        .WIDTH ($bits(prs_word_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n),
        .wr_valid_in  (push_need),
        .wr_ready_out (fifo_ready),
        .wr_data_in   (word),
        .rd_valid_out (out_valid_out),
        .rd_ready_in  (out_ready_in),
        .rd_data_out  (rd_word)
    );
    assign left_sample_out  = rd_word.left;
    assign right_sample_out = rd_word.right;
    assign sample_first_out = rd_word.first;
    assign row_end_out      = rd_word.row_end;
    assign frame_end_out    = rd_word.frame_end;

    // APB slave: zero wait, errors on unmapped offsets
    assign pready  = 1'b1;
    assign apb_hit = (paddr == REG_MODE) || (paddr == REG_LEVELS) ||
                     (paddr == REG_STATUS) || (paddr == REG_FRAMES);
    assign pslverr = psel && penable && !apb_hit;
    assign apb_wr  = psel && penable && pwrite;

    // Writable registers
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_q   <= MODE_RESET;
            levels_q <= LEVELS_RESET;
        end else if (apb_wr) begin
            if (paddr == REG_MODE) begin
                mode_q <= pwdata[4:0];
            end
            if (paddr == REG_LEVELS) begin
                levels_q <= pwdata[15:0];
            end
        end
    end

    // Read mux
    always_comb begin
        case (paddr)
            REG_MODE:   prdata = {27'h0, mode_q};
            REG_LEVELS: prdata = {16'h0, levels_q};
            REG_STATUS: prdata = {12'h0, state_q, 1'b0, row_q, 1'b0, pos_q};
            REG_FRAMES: prdata = {16'h0, frames_q};
            default:    prdata = 32'h0;
        endcase
    end

    // Checks
    AST_LATENCY: assert property (@(posedge clk_in) disable iff (!rst_n)
        (tick && state_q == ST_ARMED && !sync_token_in) |=> (state_q == ST_WAIT)
        ##40 (state_q == ST_RUN && pos_q == POS_DUMMY1 && row_q == ROW_TOP))
        else $error("Readout did not start four ticks after token low");
    AST_TOKEN: assert property (@(posedge clk_in) disable iff (!rst_n)
        (tick && sync_token_in) |=> (state_q == ST_ARMED && row_q == ROW_TOP))
        else $error("Token did not restart the frame");
    AST_ROWSTEP: assert property (@(posedge clk_in) disable iff (!rst_n)
        (tick && state_q == ST_RUN && pos_q == POS_LAST) |=>
        (pos_q == POS_DUMMY1 && row_q == $past(row_q) - 1'b1))
        else $error("Row did not step down after column zero");
    AST_DIV: assert property (@(posedge clk_in) disable iff (!rst_n)
        (tick ##1 adv [*5]) |=> !clk_out_q)
        else $error("Readout clock out not low in second half");
    AST_SLOTS: assert property (@(posedge clk_in) disable iff (!rst_n)
        (push_need && serial && slot_q > SLOT_RIGHT) |-> (word.left == dummy_level_input_in))
        else $error("Dummy slot without fixed level");
    AST_RIGHT: assert property (@(posedge clk_in) disable iff (!rst_n)
        (push_need && serial && slot_q == SLOT_RIGHT && !test && pos_q > POS_DUMMY0)
        |-> (word.left == right_pixel_in))
        else $error("Second serial slot is not the right subframe");
    AST_TESTCUT: assert property (@(posedge clk_in) disable iff (!rst_n)
        test |-> !matrix_select_out)
        else $error("Matrix selected in test mode");
    AST_PATTERN: assert property (@(posedge clk_in) disable iff (!rst_n)
        (push_need && test && !serial) |->
        (word.left == ((pos_q[1] == pos_q[0]) ? lvl_hi : lvl_lo)
         && word.right == ((pos_q[1] == pos_q[0]) ? lvl_lo : lvl_hi)))
        else $error("Test pattern wrong");
    AST_FRAMEND: assert property (@(posedge clk_in) disable iff (!rst_n)
        push_need |-> (word.frame_end == (row_q == ROW_BOTTOM)
                       && word.row_end == (pos_q == POS_LAST)))
        else $error("Row or frame marker wrong");
    AST_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n)
        (state_q == ST_RUN && $past(state_q) == ST_RUN) |-> $stable(run_mode_q))
        else $error("Mode changed during a frame");

    COV_START:  cover property (@(posedge clk_in) disable iff (!rst_n) start_q);
    COV_FRAME:  cover property (@(posedge clk_in) disable iff (!rst_n)
        tick && row_q == ROW_BOTTOM && pos_q == POS_LAST);
    COV_STALL:  cover property (@(posedge clk_in) disable iff (!rst_n) push_need && !fifo_ready);
    COV_SERIAL: cover property (@(posedge clk_in) disable iff (!rst_n) push_need && serial && test);
endmodule : prs_sequencer

// >>> tb/prs_daq_model.sv
// Acquisition side model that takes sample words off the stream
`timescale 1ns/1ps
module prs_daq_model (
    input  wire logic clk_in,    // System clock
    input  wire logic stall_in,  // High holds off acceptance
    output logic      ready_out  // Ready toward the sample stream
);
    // A stall lets the buffer fill so the sequencer must freeze, not drop words
    assign ready_out = !stall_in;
endmodule : prs_daq_model

// >>> tb/test_prs_sequencer.sv
// Self-checking bench for the pixel readout sequencer
`timescale 1ns/1ps
module test_prs_sequencer import prs_pkg::*; ;
    logic clk_in = 0, rstn_in = 0, psel = 0, penable = 0, pwrite = 0;
    logic sync_token_in = 0, stall = 1;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, out_valid_out, out_ready_in;
    logic sample_first_out, row_end_out, frame_end_out;
    logic [6:0]  row;               // Matrix row address
    logic [5:0]  col;               // Matrix column address, feeds the pixel values
    logic start_mk, reset_mk, rclk, msel;
    logic [7:0]  left_sample_out, right_sample_out;
    logic [7:0]  lw [80], rw [80];  // Captured left and right fields
    logic [2:0]  fw [80];           // Captured first, row end, frame end
    int fails = 0, n_compared = 0;
    always #10 clk_in = ~clk_in;
    prs_sequencer #(.FIFO_DEPTH(8)) i_dut (.clk_in, .rstn_in, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sync_token_in,
        .left_pixel_in({2'b00, col}), .right_pixel_in({2'b10, col}),
        .dummy_level_input_in(8'h77), .row_addr_out(row), .col_addr_out(col),
        .matrix_select_out(msel), .readout_clock_out(rclk),
        .start_marker_out(start_mk), .reset_marker_out(reset_mk), .out_valid_out, .out_ready_in,
        .left_sample_out, .right_sample_out, .sample_first_out, .row_end_out, .frame_end_out);
    prs_daq_model i_daq (.clk_in, .stall_in(stall), .ready_out(out_ready_in));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; waits for pready, data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Expected level of one subframe at a row position (levels a5 high, 3c low)
    // Pixels carry their own column number, so column order is visible
    function automatic logic [7:0] val(input int p, input int s, input logic t);
        if (t) return (((p % 4 == 0) || (p % 4 == 3)) ^ s) ? 8'ha5 : 8'h3c;
        if (p < 2) return (p == 0) ? 8'ha5 : 8'h3c;
        return {s ? 2'b10 : 2'b00, 6'(65 - p)};
    endfunction : val
    // Reset, configure, start a frame with the far side stalled, then collect n words
    task automatic run(input logic [31:0] mode, input int n);
        logic [31:0] r;
        logic e;
        int h;
        int c;
        rstn_in <= 1'b0;
        repeat (60) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        apb(1'b0, REG_LEVELS, 32'h0, r, e);
        chk(r, 32'h0);
        // Idle, top row, first slot after reset
        apb(1'b0, REG_STATUS, 32'h0, r, e);
        chk(r, 32'h00017f00);
        chk(reset_mk, 32'h1);
        apb(1'b1, REG_LEVELS, 32'h3ca5, r, e);
        apb(1'b1, REG_MODE, mode, r, e);
        apb(1'b0, REG_MODE, 32'h0, r, e);
        chk(r, mode);
        // One full divider period holds five high samples
        h = 0;
        repeat (10) begin
            @(posedge clk_in);
            h += rclk;
        end
        chk(h, 32'h5);
        sync_token_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        sync_token_in <= 1'b0;
        // Token low seen within one divider period, then four more periods
        c = 0;
        while (start_mk !== 1'b1 && c < 60) begin
            @(posedge clk_in);
            c++;
        end
        chk(c >= 42 && c <= 51, 32'h1);
        chk(reset_mk, 32'h0);
        // Long stall: buffer must sit full rather than overflow
        repeat (300) @(posedge clk_in);
        chk(out_valid_out, 32'h1);
        chk(row, 32'h7f);
        // Matrix selected at the frozen slot only in normal parallel readout
        chk(msel, !mode[0] && !mode[1]);
        stall <= 1'b0;
        for (int i = 0; i < n; i++) begin
            do @(posedge clk_in); while (!(out_valid_out === 1'b1 && out_ready_in === 1'b1));
            lw[i] = left_sample_out;
            rw[i] = right_sample_out;
            fw[i] = {sample_first_out, row_end_out, frame_end_out};
        end
        stall <= 1'b1;
    endtask : run
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // Main sequence: unmapped access, then one run per output format
    initial begin
        logic [31:0] r;
        logic e;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk(r, 32'h0);
        chk(e, 32'h1);
        run(32'h0, 66);
        for (int i = 0; i < 66; i++) begin
            chk({lw[i], rw[i]}, {val(i, 0, 1'b0), val(i, 1, 1'b0)});
            chk(fw[i], {i == 0, i == 65, 1'b0});
        end
        run(32'h1, 30);
        for (int i = 0; i < 30; i++) begin
            chk(lw[i], (i % 10 < 2) ? val(i / 10, i % 10, 1'b0) : 8'h77);
        end
        run(32'h2, 8);
        for (int i = 0; i < 8; i++) begin
            chk({lw[i], rw[i]}, {val(i, 0, 1'b1), val(i, 1, 1'b1)});
        end
        run(32'h10, 2);
        chk(fw[0][2] ^ fw[1][2], 32'h1);
        final_report();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #400000;
        fails++;
        final_report();
    end
endmodule : test_prs_sequencer
